/* File: rtl/fs_regs.svh */
/*
 * Opcodes, timing figures and reset values of the flash program/erase sequencer.
 * Assumes it is included by its bare name from rtl/ sources only.
 */
`ifndef FS_REGS_SVH
`define FS_REGS_SVH

`define FS_OP_WREN      8'h06
`define FS_OP_RDSR      8'h05
`define FS_OP_SE        8'hD8
`define FS_OP_SSE_A     8'h20
`define FS_OP_SSE_B     8'hD7
`define FS_OP_PP        8'h02

`define FS_CLK_HZ       250000000
`define FS_CLK_KHZ      250000
`define FS_TPP_TYP_MS   4
`define FS_TSSE_TYP_MS  40
`define FS_TSE_TYP_MS   80
`define FS_TSRW_TYP_MS  5
`define FS_TCHE_TYP_S   0.25

`define FS_SYNC_RST     3'h2
`define FS_SR_RST       6'h00

`endif

/* File: rtl/fs_pkg.sv */
/*
 * Types shared by the flash program/erase sequencer.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package fs_pkg;
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_SE   = 3'h1,
		OP_SSE  = 3'h2,
		OP_PP   = 3'h3,
		OP_CE   = 3'h4,
		OP_SRW  = 3'h5
	} fs_op_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} fs_state_t;
endpackage
`default_nettype wire

/* File: rtl/fs_sync.sv */
/*
 * Two-flop synchroniser for a group of asynchronous pins.
 * Assumes each bit is an independent level; RST gives the idle level per bit.
 */
`default_nettype none
module fs_sync #(
	parameter int            W   = 3,
	parameter logic [W-1:0]  RST = '0
)(
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic [W-1:0]  d_in,
	output logic      [W-1:0]  d_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic meta_ff;
			logic sync_ff;
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					meta_ff <= RST[i];
					sync_ff <= RST[i];
				end
				else
				begin
					meta_ff <= d_in[i];
					sync_ff <= meta_ff;
				end
			end
			assign d_out[i] = sync_ff;
		end
	endgenerate
endmodule
`default_nettype wire

/* File: rtl/fs_fifo.sv */
/*
 * Flop-based FIFO with valid/ready on both sides and a synchronous flush.
 * Assumes D is a power of two.
 */
`default_nettype none
module fs_fifo #(
	parameter int W = 8,
	parameter int D = 16
)(
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          flush,
	input  wire logic          wr_valid,
	output logic               wr_ready,
	input  wire logic [W-1:0]  wr_data,
	output logic               rd_valid,
	input  wire logic          rd_ready,
	output logic      [W-1:0]  rd_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_ff [D];
	logic [AW:0]   wp_ff;
	logic [AW:0]   rp_ff;

	assign rd_valid = wp_ff != rp_ff;
	assign wr_ready = !((wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]));
	assign rd_data  = mem_ff[rp_ff[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (wr_valid && wr_ready)
			mem_ff[wp_ff[AW-1:0]] <= wr_data;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
		end
		else if (flush)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
		end
		else
		begin
			if (wr_valid && wr_ready)
				wp_ff <= wp_ff + 1'b1;
			if (rd_valid && rd_ready)
				rp_ff <= rp_ff + 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/fs_seq_top.sv */
/*
 * Serial flash command sequencer, device end: decodes write enable, erase,
 * page program and status write from the SPI pins, times the internal
 * operation and answers status reads.
 * Assumes SCK, CS_N and SI arrive asynchronously and SCK is well below clk/4.
 */
`include "fs_regs.svh"
`default_nettype none
module fs_seq_top
	import fs_pkg::*;
#(
	parameter logic [7:0]   CE_OPCODE  = 8'hC7,
	parameter logic [7:0]   SRW_OPCODE = 8'h01,
	parameter logic [31:0]  PP_CYC     = 32'(`FS_TPP_TYP_MS * `FS_CLK_KHZ),
	parameter logic [31:0]  SSE_CYC    = 32'(`FS_TSSE_TYP_MS * `FS_CLK_KHZ),
	parameter logic [31:0]  SE_CYC     = 32'(`FS_TSE_TYP_MS * `FS_CLK_KHZ),
	parameter logic [31:0]  SRW_CYC    = 32'(`FS_TSRW_TYP_MS * `FS_CLK_KHZ),
	parameter logic [31:0]  CE_CYC     = 32'($rtoi(`FS_TCHE_TYP_S * `FS_CLK_HZ))
)(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        si,
	output logic             so,
	output logic             so_oe,
	output logic             op_start,
	output fs_op_t           op_kind,
	output logic [23:0]      op_addr,
	output logic             busy,
	output logic             wel,
	output logic [5:0]       prot_bits,
	output logic             pg_valid,
	input  wire logic        pg_ready,
	output logic [7:0]       pg_data,
	output logic             pg_overflow
);
	////////////////////////////////////////////////////////////////////////////
	logic [2:0]   pins_s;
	logic         sck_s;
	logic         cs_n_s;
	logic         si_s;
	logic         sck_q_ff;
	logic         cs_n_q_ff;
	logic [2:0]   bit_cnt_ff;
	logic [3:0]   byte_cnt_ff;
	logic [7:0]   shreg_ff;
	logic [7:0]   op_ff;
	logic         ign_ff;
	logic [23:0]  addr_ff;
	logic [7:0]   srw_data_ff;
	logic [5:0]   sr_ff;
	logic         wel_ff;
	fs_state_t    state_ff;
	logic [31:0]  timer_ff;
	fs_op_t       kind_ff;
	logic         start_ff;
	logic         so_ff;
	logic         ovf_ff;
	logic [31:0]  busy_len_ff;

	fs_sync #(
		.W   (3),
		.RST (`FS_SYNC_RST)
	) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d_in    ({si, cs_n, sck}),
		.d_out   (pins_s)
	);
	assign sck_s  = pins_s[0];
	assign cs_n_s = pins_s[1];
	assign si_s   = pins_s[2];

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sck_q_ff  <= 1'b0;
			cs_n_q_ff <= 1'b1;
		end
		else
		begin
			sck_q_ff  <= sck_s;
			cs_n_q_ff <= cs_n_s;
		end
	end

	logic        sck_rise;
	logic        sck_fall;
	logic        cs_fall;
	logic        cs_rise;
	logic        byte_done;
	logic [7:0]  new_byte;
	logic [7:0]  status;
	logic        busy_ff;

	assign sck_rise  = sck_s & ~sck_q_ff & ~cs_n_s;
	assign sck_fall  = ~sck_s & sck_q_ff & ~cs_n_s;
	assign cs_fall   = ~cs_n_s & cs_n_q_ff;
	assign cs_rise   = cs_n_s & ~cs_n_q_ff;
	assign byte_done = sck_rise && bit_cnt_ff == 3'h7;
	assign new_byte  = {shreg_ff[6:0], si_s};
	assign busy_ff   = state_ff == ST_BUSY;
	assign status    = {sr_ff, wel_ff, busy_ff};

	////////////////////////////////////////////////////////////////////////////
	// Shifter and byte framing
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bit_cnt_ff  <= 3'h0;
			byte_cnt_ff <= 4'h0;
			shreg_ff    <= 8'h00;
		end
		else if (cs_fall)
		begin
			bit_cnt_ff  <= 3'h0;
			byte_cnt_ff <= 4'h0;
		end
		else if (sck_rise)
		begin
			shreg_ff   <= new_byte;
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (byte_done && byte_cnt_ff != 4'hF)
				byte_cnt_ff <= byte_cnt_ff + 4'h1;
		end
	end

	// Busy device drops everything but status read for the whole frame
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			op_ff  <= 8'h00;
			ign_ff <= 1'b0;
		end
		else if (cs_fall)
		begin
			op_ff  <= 8'h00;
			ign_ff <= 1'b0;
		end
		else if (byte_done && byte_cnt_ff == 4'h0)
		begin
			op_ff  <= new_byte;
			ign_ff <= busy_ff && new_byte != `FS_OP_RDSR;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addr_ff     <= 24'h000000;
			srw_data_ff <= 8'h00;
		end
		else if (byte_done)
		begin
			if (byte_cnt_ff >= 4'h1 && byte_cnt_ff <= 4'h3)
				addr_ff <= {addr_ff[15:0], new_byte};
			if (byte_cnt_ff == 4'h1)
				srw_data_ff <= new_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Page buffer; a page longer than the FIFO overflows, the excess is lost
	logic  push;
	logic  fifo_wr_ready;
	logic  fifo_rd_valid;
	logic  pgm_active;
	logic  flush;

	assign push = byte_done && byte_cnt_ff >= 4'h4 && op_ff == `FS_OP_PP && !ign_ff;
	assign pgm_active = busy_ff && kind_ff == OP_PP;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ovf_ff <= 1'b0;
		else if (push && !fifo_wr_ready)
			ovf_ff <= 1'b1;
		else if (cs_fall)
			ovf_ff <= 1'b0;
	end

	fs_fifo #(
		.W (8),
		.D (16)
	) u_fifo (
		.clk      (clk),
		.reset_n  (reset_n),
		.flush    (flush),
		.wr_valid (push),
		.wr_ready (fifo_wr_ready),
		.wr_data  (new_byte),
		.rd_valid (fifo_rd_valid),
		.rd_ready (pg_ready & pgm_active),
		.rd_data  (pg_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Command acceptance at the closing chip-select rise
	logic    go;
	fs_op_t  nxt_kind;
	logic    start;

	assign go = cs_rise && bit_cnt_ff == 3'h0 && !busy_ff && !ign_ff;

	always_comb
	begin
		nxt_kind = OP_NONE;
		case (op_ff)
			`FS_OP_SE:
				if (byte_cnt_ff == 4'h4)
					nxt_kind = OP_SE;
			`FS_OP_SSE_A, `FS_OP_SSE_B:
				if (byte_cnt_ff == 4'h4)
					nxt_kind = OP_SSE;
			`FS_OP_PP:
				if (byte_cnt_ff >= 4'h5)
					nxt_kind = OP_PP;
			CE_OPCODE:
				if (byte_cnt_ff == 4'h1)
					nxt_kind = OP_CE;
			SRW_OPCODE:
				if (byte_cnt_ff == 4'h2)
					nxt_kind = OP_SRW;
			default:
				nxt_kind = OP_NONE;
		endcase
	end

	assign start = go && wel_ff && nxt_kind != OP_NONE;
	assign flush = cs_rise && !(start && nxt_kind == OP_PP) && !pgm_active;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wel_ff <= 1'b0;
		else if (go && op_ff == `FS_OP_WREN && byte_cnt_ff == 4'h1)
			wel_ff <= 1'b1;
		else if (busy_ff && timer_ff == 32'h0)
			wel_ff <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			sr_ff <= `FS_SR_RST;
		else if (start && nxt_kind == OP_SRW)
			sr_ff <= srw_data_ff[7:2];
	end

	////////////////////////////////////////////////////////////////////////////
	// Operation timer
	logic [31:0] load_cyc;

	always_comb
	begin
		case (nxt_kind)
			OP_SE:   load_cyc = SE_CYC;
			OP_SSE:  load_cyc = SSE_CYC;
			OP_PP:   load_cyc = PP_CYC;
			OP_CE:   load_cyc = CE_CYC;
			OP_SRW:  load_cyc = SRW_CYC;
			default: load_cyc = 32'h1;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff <= ST_IDLE;
			timer_ff <= 32'h0;
			kind_ff  <= OP_NONE;
			start_ff <= 1'b0;
		end
		else
		begin
			start_ff <= start;
			case (state_ff)
				ST_IDLE:
					if (start)
					begin
						state_ff <= ST_BUSY;
						timer_ff <= load_cyc - 32'h1;
						kind_ff  <= nxt_kind;
					end
				ST_BUSY:
					if (timer_ff == 32'h0)
						state_ff <= ST_IDLE;
					else
						timer_ff <= timer_ff - 32'h1;
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// Status byte streams MSB first, repeating, launched on SCK fall
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			so_ff <= 1'b0;
		else if (sck_fall && op_ff == `FS_OP_RDSR && byte_cnt_ff != 4'h0)
			so_ff <= status[~bit_cnt_ff];
	end

	assign so          = so_ff;
	assign so_oe       = !cs_n_s && op_ff == `FS_OP_RDSR && byte_cnt_ff != 4'h0;
	assign op_start    = start_ff;
	assign op_kind     = kind_ff;
	assign op_addr     = addr_ff;
	assign busy        = busy_ff;
	assign wel         = wel_ff;
	assign prot_bits   = sr_ff;
	assign pg_valid    = fifo_rd_valid & pgm_active;
	assign pg_overflow = ovf_ff;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			busy_len_ff <= 32'h0;
		else
			busy_len_ff <= busy_ff ? busy_len_ff + 32'h1 : 32'h0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	erase_on_rise_a: assert property (start_ff |-> $past(cs_rise))
		else $error("operation started without a chip-select rise");
	pp_on_rise_a: assert property (start_ff && kind_ff == OP_PP |->
		$past(cs_rise) && $past(op_ff) == `FS_OP_PP)
		else $error("program started off the closing edge");
	sse_alias_a: assert property (start_ff && kind_ff == OP_SSE |->
		$past(op_ff) == `FS_OP_SSE_A || $past(op_ff) == `FS_OP_SSE_B)
		else $error("small erase from wrong opcode");
	addr_msb_a: assert property (byte_done && byte_cnt_ff == 4'h3 |=>
		addr_ff[7:0] == $past(new_byte) && addr_ff[15:8] == $past(addr_ff[7:0]))
		else $error("address bytes misordered");
	busy_bit_a: assert property (sck_fall && so_oe && bit_cnt_ff == 3'h7 |=>
		so == $past(busy_ff))
		else $error("status bit 0 is not busy");
	wel_auto_a: assert property ($fell(busy_ff) |-> !wel_ff)
		else $error("write enable survived the operation");
	srw_wel_a: assert property ($fell(busy_ff) && kind_ff == OP_SRW |-> !wel_ff)
		else $error("write enable survived status write");
	pp_time_a: assert property ($fell(busy_ff) && kind_ff == OP_PP |-> busy_len_ff == PP_CYC)
		else $error("program busy time wrong");
	erase_time_a: assert property ($fell(busy_ff) && kind_ff == OP_SE |-> busy_len_ff == SE_CYC)
		else $error("sector erase busy time wrong");
	ce_time_a: assert property ($fell(busy_ff) && kind_ff == OP_CE |-> busy_len_ff == CE_CYC)
		else $error("chip erase busy time wrong");
	srw_time_a: assert property ($fell(busy_ff) && kind_ff == OP_SRW |-> busy_len_ff == SRW_CYC)
		else $error("status write busy time wrong");
	byte_bound_a: assert property (cs_rise && bit_cnt_ff != 3'h0 |=> !start_ff && $stable(wel_ff))
		else $error("partial byte command accepted");
	srw_len_a: assert property (cs_rise && op_ff == SRW_OPCODE && byte_cnt_ff > 4'h2 |=> !start_ff)
		else $error("long status write accepted");
	busy_lock_a: assert property (busy_ff && cs_rise |=> !start_ff && !$rose(wel_ff))
		else $error("command accepted while busy");
	pp_push_a: assert property (push |-> op_ff == `FS_OP_PP)
		else $error("data buffered outside page program");

	se_run_c: cover property (start_ff && kind_ff == OP_SE);
	pp_run_c: cover property (start_ff && kind_ff == OP_PP ##[1:40] pg_valid && pg_ready);
	poll_busy_c: cover property (busy_ff && so_oe);
	op_done_c: cover property ($fell(busy_ff));
endmodule
`default_nettype wire

/* File: tb/fs_host_model.sv */
/*
 * SPI host model: drives mode 0 command frames and samples so on each sck rise.
 * Assumes the device samples si on sck rise and changes so after sck fall.
 */
`default_nettype none
module fs_host_model (
	output var logic  sck,
	output var logic  cs_n,
	output var logic  si,
	input  wire logic so,
	input  wire logic so_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Clock stands low between frames; a 64 ns period keeps every command legal
	task automatic xfer(input logic [255:0] d, input int n, output logic [7:0] rx);
		rx = 8'h00;
		#1.5;
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			si = d[i];
			#32 sck = 1'b1;
			rx = {rx[6:0], so_oe ? so : 1'bx};
			#32 sck = 1'b0;
		end
		#8 cs_n = 1'b1;
		// A deselected data line must not keep showing its last bit
		si = ~si;
		#24;
	endtask
endmodule
`default_nettype wire

/* File: tb/fs_seq_top_tb.sv */
/*
 * Self-checking bench of the flash program/erase sequencer.
 * Assumes the host model in tb/ and shortened busy counts.
 */
`default_nettype none
module fs_seq_top_tb;
	import fs_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [31:0] SE_C  = 32'd600;
	localparam logic [31:0] SSE_C = 32'd550;
	localparam logic [31:0] PP_C  = 32'd700;
	localparam logic [31:0] SRW_C = 32'd500;
	localparam logic [31:0] CE_C  = 32'd650;

	logic          clk;
	logic          reset_n;
	logic          pg_ready;
	wire logic     sck;
	wire logic     cs_n;
	wire logic     si;
	logic          so;
	logic          so_oe;
	logic          op_start;
	fs_op_t        op_kind;
	logic [23:0]   op_addr;
	logic          busy;
	logic          wel;
	logic [5:0]    prot_bits;
	logic          pg_valid;
	logic [7:0]    pg_data;
	logic          pg_overflow;
	logic [7:0]    rx;
	logic [7:0]    got [0:31];
	logic [5:0]    exp_prot;
	logic [255:0]  d;
	logic          ovf = 1'b0;
	int            ng = 0;
	int            bad = 0;
	int            bcnt = 0;
	int            nstart = 0;
	int            n_errors;
	int            checked;

	fs_host_model i_fs_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

	fs_seq_top #(.PP_CYC(PP_C), .SSE_CYC(SSE_C), .SE_CYC(SE_C), .SRW_CYC(SRW_C),
		.CE_CYC(CE_C)) i_fs_seq_top (
		.clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
		.busy(busy), .wel(wel), .prot_bits(prot_bits), .pg_valid(pg_valid),
		.pg_ready(pg_ready), .pg_data(pg_data), .pg_overflow(pg_overflow));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Array side stalls every other cycle so the buffer drains slowly
	always @(posedge clk or negedge reset_n)
		if (!reset_n)
			pg_ready <= 1'b0;
		else
			pg_ready <= ~pg_ready;

	always @(posedge clk)
	begin
		if (pg_valid === 1'b1 && pg_ready === 1'b1)
		begin
			got[ng[4:0]] <= pg_data;
			ng <= ng + 1;
		end
		// Program data leaves only while programming; no start with cs_n still low
		if (pg_valid === 1'b1 && !(busy === 1'b1 && op_kind === OP_PP))
			bad <= bad + 1;
		if (op_start === 1'b1 && cs_n !== 1'b1)
			bad <= bad + 1;
		if (pg_overflow === 1'b1)
			ovf <= 1'b1;
		if (op_start === 1'b1)
		begin
			bcnt <= 1;
			nstart <= nstart + 1;
		end
		else if (busy === 1'b1)
			bcnt <= bcnt + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic send(input logic [255:0] dd, input int n);
		i_fs_host_model.xfer(dd, n, rx);
	endtask

	task automatic rdsr(input logic [7:0] exp);
		send(16'h0500, 16);
		chk(rx, exp);
	endtask

	task automatic wait_flag(input bit want_start);
		int k;
		for (k = 0; k < 2000 && (want_start ? busy !== 1'b1 : busy !== 1'b0); k++)
		begin
			@(posedge clk);
			#1;
		end
		if (k == 2000)
		begin
			n_errors++;
			close_out();
		end
	endtask

	task automatic run_op(input logic [255:0] dd, input int n, input fs_op_t k,
		input logic [23:0] a, input logic [31:0] cyc);
		int s;
		send(8'h06, 8);
		repeat (6) @(posedge clk);
		#1;
		chk(wel, 1'b1);
		s = nstart;
		// The start pulse is over before the host model hands back control
		send(dd, n);
		chk(busy, 1'b1);
		wait_flag(1'b1);
		chk(nstart, s + 1);
		chk(op_kind, k);
		if (k inside {OP_SE, OP_SSE, OP_PP})
			chk(op_addr, a);
		rdsr({exp_prot, 2'b11});
		// Write enable sent mid-operation must not survive the automatic clear
		send(8'h06, 8);
		wait_flag(1'b0);
		chk(bcnt, cyc);
		chk(wel, 1'b0);
		rdsr({exp_prot, 2'b00});
	endtask

	task automatic refused(input logic [255:0] dd, input int n, input logic w);
		int s;
		s = nstart;
		if (w)
			send(8'h06, 8);
		send(dd, n);
		repeat (10) @(posedge clk);
		#1;
		chk(nstart, s);
		chk(busy, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n = 1'b0;
		n_errors = 0;
		checked = 0;
		exp_prot = 6'h00;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk({so_oe, op_start, busy, wel, prot_bits, pg_valid, pg_overflow}, 32'h0);
		run_op({8'hD8, 24'hABCDEF}, 32, OP_SE, 24'hABCDEF, SE_C);
		run_op({8'h20, 24'h001000}, 32, OP_SSE, 24'h001000, SSE_C);
		run_op({8'hD7, 24'h0FF000}, 32, OP_SSE, 24'h0FF000, SSE_C);
		refused({8'hD8, 24'h010000}, 32, 1'b0);
		refused({8'hD8, 24'h010000, 1'b0}, 33, 1'b1);
		refused({8'h01, 8'hFC, 8'h00}, 24, 1'b1);
		rdsr(8'h02);
		exp_prot = 6'h2B;
		run_op({8'h01, 8'hAC}, 16, OP_SRW, 24'h0, SRW_C);
		// Seventeen data bytes: one more than the buffer holds
		d = {8'h02, 24'h012345};
		for (int i = 0; i < 17; i++)
			d = {d[247:0], 8'(8'hA0 + i)};
		run_op(d, 168, OP_PP, 24'h012345, PP_C);
		chk(ng, 16);
		chk(ovf, 1'b1);
		for (int i = 0; i < 16; i++)
			chk(got[i], 8'(8'hA0 + i));
		chk(bad, 0);
		run_op(8'hC7, 8, OP_CE, 24'h0, CE_C);
		close_out();
	end
endmodule
`default_nettype wire
